// ==== core/ebtco_timer.sv ====
`timescale 1ns/10ps
`include "ebtco_defs.svh"
// What this block does
// R1: a counter write blocks every compare match in the next timer tick, even stopped
// R2: action field is used directly, never buffered with the compare value
// R3: compare output bits keep their level across waveform mode changes
// R4: reset clears the internal compare output bits to zero
// R5: nonzero action field routes compare output to the pin; direction stays port's
// R6: compare level reaches the pin only while its direction bit is output
// R7: pin source choice depends on action field only, not waveform mode
// R8: action field zero leaves compare output unchanged on a match
// R9: new action acts at next match; force strobe applies it at once in non-pwm modes
// R10: waveform mode alone sets the count sequence; action only shapes output
// R11: normal mode always increments, wrapping from ff to 00
// R12: normal mode sets overflow flag on the tick the counter becomes zero
// R13: overflow flag clears when the overflow interrupt is executed
// R14: clear-on-match mode clears counter on the tick after matching compare a
// R15: compare a below count lets counter run to ff, wrap, then match
// R16: clear-on-match mode sets compare flag a each time top is reached
// R17: action 1 in clear-on-match mode toggles output a on every match
// R18: toggle rate set by prescaler factor; compare value 00 gives fastest rate
// R19: clear-on-match mode sets overflow flag passing from ff to 00
// R20: software sets compare output level before making the pin an output
// R21: software avoids writing a count equal to a compare value
// R22: forced compare updates output only; no flag, no counter clear or reload
// R23: a match sets its compare flag at the next timer tick
// R24: a counter write beats any clear or count in the same cycle
// R25: counting, compare and flags run on clk and advance only on timer_tick
module ebtco_timer (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_tick,
  input wire logic ovf_int_ack,
  input wire logic cmpa_int_ack,
  input wire logic cmpb_int_ack,
  output logic overflow_flag,
  output logic compare_flag_a,
  output logic compare_flag_b,
  output logic pin_a_out,
  output logic pin_a_oe,
  output logic pin_b_out,
  output logic pin_b_oe,
  output ebtco_pkg::ebtco_byte_t counter_value
);
  import ebtco_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  ebtco_mode_e waveform_mode_select, next_waveform_mode_select;
  ebtco_act_e compare_action_field_a, next_compare_action_field_a;
  ebtco_act_e compare_action_field_b, next_compare_action_field_b;
  ebtco_byte_t next_counter_value;
  ebtco_byte_t compare_value_a, next_compare_value_a;
  ebtco_byte_t compare_value_b, next_compare_value_b;
  logic match_block, next_match_block;
  logic compare_output_a, next_compare_output_a;
  logic compare_output_b, next_compare_output_b;
  logic next_overflow_flag, next_compare_flag_a, next_compare_flag_b;
  logic port_val_a, next_port_val_a, port_val_b, next_port_val_b;
  logic compare_pin_direction_bit_a, next_compare_pin_direction_bit_a;
  logic compare_pin_direction_bit_b, next_compare_pin_direction_bit_b;
  logic [31:0] next_prdata;

  logic acc, wr, setup, mapped, lane0;
  logic wr_ctrl, wr_cnt, wr_cmpa, wr_cmpb, wr_force, wr_flags, wr_port;
  logic non_pwm, match_a, match_b, do_a, do_b, match_clear, force_a, force_b;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic apply_act(input logic oc, input ebtco_act_e act);
    case (act)
      EBTCO_ACT_NONE: apply_act = oc; // R8
      EBTCO_ACT_TOGGLE: apply_act = ~oc; // R17
      EBTCO_ACT_CLEAR: apply_act = 1'b0;
      EBTCO_ACT_SET: apply_act = 1'b1;
      default: apply_act = oc;
    endcase
  endfunction : apply_act

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // apb decode: zero wait, unmapped answers pslverr

  always_comb begin
    mapped = hit(paddr, `EBTCO_OFF_CTRL) || hit(paddr, `EBTCO_OFF_COUNT) ||
             hit(paddr, `EBTCO_OFF_CMPA) || hit(paddr, `EBTCO_OFF_CMPB) ||
             hit(paddr, `EBTCO_OFF_FORCE) || hit(paddr, `EBTCO_OFF_FLAGS) ||
             hit(paddr, `EBTCO_OFF_PORT) || hit(paddr, `EBTCO_OFF_OUTS);
    setup = psel && !penable;
    acc = psel && penable;
    // all registers are one byte wide; only lane 0 carries them
    lane0 = pstrb[0];
    wr = acc && pwrite && lane0;
    wr_ctrl = wr && hit(paddr, `EBTCO_OFF_CTRL);
    wr_cnt = wr && hit(paddr, `EBTCO_OFF_COUNT);
    wr_cmpa = wr && hit(paddr, `EBTCO_OFF_CMPA);
    wr_cmpb = wr && hit(paddr, `EBTCO_OFF_CMPB);
    wr_force = wr && hit(paddr, `EBTCO_OFF_FORCE);
    wr_flags = wr && hit(paddr, `EBTCO_OFF_FLAGS);
    wr_port = wr && hit(paddr, `EBTCO_OFF_PORT);
    pready = 1'b1;
    pslverr = acc && !mapped;
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter, compare units and flags

  always_comb begin
    next_waveform_mode_select = waveform_mode_select;
    next_compare_action_field_a = compare_action_field_a;
    next_compare_action_field_b = compare_action_field_b;
    next_counter_value = counter_value;
    next_compare_value_a = compare_value_a;
    next_compare_value_b = compare_value_b;
    next_match_block = match_block;
    next_compare_output_a = compare_output_a;
    next_compare_output_b = compare_output_b;
    next_overflow_flag = overflow_flag;
    next_compare_flag_a = compare_flag_a;
    next_compare_flag_b = compare_flag_b;
    next_port_val_a = port_val_a;
    next_port_val_b = port_val_b;
    next_compare_pin_direction_bit_a = compare_pin_direction_bit_a;
    next_compare_pin_direction_bit_b = compare_pin_direction_bit_b;

    non_pwm = (waveform_mode_select == EBTCO_MODE_NORMAL) ||
              (waveform_mode_select == EBTCO_MODE_CLRMATCH);
    // plain equality: a top below the count is only met after the wrap
    match_a = timer_tick && !match_block && (counter_value == compare_value_a); // R1 R15 R25
    match_b = timer_tick && !match_block && (counter_value == compare_value_b); // R1 R25
    match_clear = match_a && (waveform_mode_select == EBTCO_MODE_CLRMATCH); // R14 R10 R18
    force_a = wr_force && pwdata[`EBTCO_BIT_A] && non_pwm; // R9 R22
    force_b = wr_force && pwdata[`EBTCO_BIT_B] && non_pwm; // R9 R22
    // pwm waveforms live elsewhere; here matches only act in non-pwm modes
    do_a = (match_a && non_pwm) || force_a;
    do_b = (match_b && non_pwm) || force_b;
    // a match and a force in one cycle act once, not twice
    if (do_a) begin
      next_compare_output_a = apply_act(compare_output_a, compare_action_field_a); // R2 R9
    end
    if (do_b) begin
      next_compare_output_b = apply_act(compare_output_b, compare_action_field_b); // R2 R9
    end

    if (timer_tick) begin
      next_match_block = 1'b0; // R1
      if (match_clear) begin
        next_counter_value = `EBTCO_CNT_ZERO; // R14
      end else begin
        next_counter_value = counter_value + `EBTCO_CNT_ONE; // R11 R15
      end
    end
    if (wr_cnt) begin
      next_counter_value = pwdata[7:0]; // R24
      next_match_block = 1'b1; // R1
    end

    // clears first so that a set in the same cycle wins
    if ((wr_flags && pwdata[`EBTCO_FLG_OVF]) || ovf_int_ack) begin
      next_overflow_flag = 1'b0; // R13
    end
    if ((wr_flags && pwdata[`EBTCO_FLG_CMPA]) || cmpa_int_ack) begin
      next_compare_flag_a = 1'b0;
    end
    if ((wr_flags && pwdata[`EBTCO_FLG_CMPB]) || cmpb_int_ack) begin
      next_compare_flag_b = 1'b0;
    end
    if (timer_tick && non_pwm && counter_value == `EBTCO_CNT_MAX) begin
      next_overflow_flag = 1'b1; // R12 R19
    end
    if (match_a) begin
      next_compare_flag_a = 1'b1; // R16 R23
    end
    if (match_b) begin
      next_compare_flag_b = 1'b1; // R23
    end

    if (wr_ctrl) begin
      // mode change leaves the compare output bits alone
      next_waveform_mode_select = ebtco_mode_e'(pwdata[`EBTCO_CTRL_WGM]); // R3 R10
      next_compare_action_field_a = ebtco_act_e'(pwdata[`EBTCO_CTRL_ACTA]); // R2
      next_compare_action_field_b = ebtco_act_e'(pwdata[`EBTCO_CTRL_ACTB]); // R2
    end
    if (wr_cmpa) begin
      next_compare_value_a = pwdata[7:0]; // R15
    end
    if (wr_cmpb) begin
      next_compare_value_b = pwdata[7:0];
    end
    if (wr_port) begin
      next_port_val_a = pwdata[`EBTCO_PORT_VALA];
      next_port_val_b = pwdata[`EBTCO_PORT_VALB];
      next_compare_pin_direction_bit_a = pwdata[`EBTCO_PORT_DIRA];
      next_compare_pin_direction_bit_b = pwdata[`EBTCO_PORT_DIRB];
    end

    // read data captured in setup so it is steady through the access phase
    next_prdata = prdata;
    if (setup) begin
      next_prdata = `EBTCO_RST_WORD;
      case (paddr)
        `EBTCO_OFF_CTRL: begin
          next_prdata[`EBTCO_CTRL_WGM] = waveform_mode_select;
          next_prdata[`EBTCO_CTRL_ACTA] = compare_action_field_a;
          next_prdata[`EBTCO_CTRL_ACTB] = compare_action_field_b;
        end
        `EBTCO_OFF_COUNT: next_prdata[7:0] = counter_value;
        `EBTCO_OFF_CMPA: next_prdata[7:0] = compare_value_a;
        `EBTCO_OFF_CMPB: next_prdata[7:0] = compare_value_b;
        `EBTCO_OFF_FLAGS: begin
          next_prdata[`EBTCO_FLG_OVF] = overflow_flag;
          next_prdata[`EBTCO_FLG_CMPA] = compare_flag_a;
          next_prdata[`EBTCO_FLG_CMPB] = compare_flag_b;
        end
        `EBTCO_OFF_PORT: begin
          next_prdata[`EBTCO_PORT_VALA] = port_val_a;
          next_prdata[`EBTCO_PORT_VALB] = port_val_b;
          next_prdata[`EBTCO_PORT_DIRA] = compare_pin_direction_bit_a;
          next_prdata[`EBTCO_PORT_DIRB] = compare_pin_direction_bit_b;
        end
        `EBTCO_OFF_OUTS: begin
          next_prdata[`EBTCO_BIT_A] = compare_output_a;
          next_prdata[`EBTCO_BIT_B] = compare_output_b;
        end
        default: next_prdata = `EBTCO_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      waveform_mode_select <= EBTCO_MODE_NORMAL;
      compare_action_field_a <= EBTCO_ACT_NONE;
      compare_action_field_b <= EBTCO_ACT_NONE;
      counter_value <= `EBTCO_RST_BYTE;
      compare_value_a <= `EBTCO_RST_BYTE;
      compare_value_b <= `EBTCO_RST_BYTE;
      match_block <= 1'b0;
      compare_output_a <= 1'b0; // R4
      compare_output_b <= 1'b0; // R4
      overflow_flag <= 1'b0;
      compare_flag_a <= 1'b0;
      compare_flag_b <= 1'b0;
      port_val_a <= 1'b0;
      port_val_b <= 1'b0;
      compare_pin_direction_bit_a <= 1'b0;
      compare_pin_direction_bit_b <= 1'b0;
      prdata <= `EBTCO_RST_WORD;
    end else begin
      waveform_mode_select <= next_waveform_mode_select;
      compare_action_field_a <= next_compare_action_field_a;
      compare_action_field_b <= next_compare_action_field_b;
      counter_value <= next_counter_value;
      compare_value_a <= next_compare_value_a;
      compare_value_b <= next_compare_value_b;
      match_block <= next_match_block;
      compare_output_a <= next_compare_output_a;
      compare_output_b <= next_compare_output_b;
      overflow_flag <= next_overflow_flag;
      compare_flag_a <= next_compare_flag_a;
      compare_flag_b <= next_compare_flag_b;
      port_val_a <= next_port_val_a;
      port_val_b <= next_port_val_b;
      compare_pin_direction_bit_a <= next_compare_pin_direction_bit_a;
      compare_pin_direction_bit_b <= next_compare_pin_direction_bit_b;
      prdata <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin override: source by action field only, drive by direction bit only

  always_comb begin
    pin_a_out = (compare_action_field_a != EBTCO_ACT_NONE) ? compare_output_a : port_val_a; // R5 R7
    pin_b_out = (compare_action_field_b != EBTCO_ACT_NONE) ? compare_output_b : port_val_b; // R5 R7
    pin_a_oe = compare_pin_direction_bit_a; // R6
    pin_b_oe = compare_pin_direction_bit_b; // R6
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  block_after_write_a: assert property ( // R1
    (timer_tick && match_block && !compare_flag_a && !wr_force)
    |=> !compare_flag_a && $stable(compare_output_a))
    else $error("compare a acted in tick after counter write");

  block_armed_a: assert property ( // R1
    wr_cnt |=> match_block)
    else $error("counter write did not block matches");

  write_wins_a: assert property ( // R24
    wr_cnt |=> counter_value == $past(pwdata[7:0]))
    else $error("counter write lost");

  normal_increment_a: assert property ( // R11
    (timer_tick && !wr_cnt && waveform_mode_select == EBTCO_MODE_NORMAL)
    |=> counter_value == ($past(counter_value) + `EBTCO_CNT_ONE))
    else $error("normal mode did not increment");

  match_clear_a: assert property ( // R14
    (timer_tick && !wr_cnt && !match_block && waveform_mode_select == EBTCO_MODE_CLRMATCH &&
     counter_value == compare_value_a) |=> counter_value == `EBTCO_CNT_ZERO)
    else $error("clear-on-match did not clear");

  overflow_set_a: assert property ( // R12 R19
    (timer_tick && non_pwm && counter_value == `EBTCO_CNT_MAX) |=> overflow_flag)
    else $error("overflow flag not set at wrap");

  overflow_ack_a: assert property ( // R13
    (ovf_int_ack && !(timer_tick && counter_value == `EBTCO_CNT_MAX)) |=> !overflow_flag)
    else $error("overflow flag not cleared by ack");

  flag_a_set_a: assert property ( // R16 R23
    (timer_tick && !match_block && counter_value == compare_value_a) |=> compare_flag_a)
    else $error("compare flag a not set on match");

  action_zero_a: assert property ( // R8
    (compare_action_field_a == EBTCO_ACT_NONE) |=> $stable(compare_output_a))
    else $error("output a moved with action none");

  force_only_out_a: assert property ( // R22 R9
    (wr_force && pwdata[`EBTCO_BIT_A] && non_pwm && !timer_tick && !cmpa_int_ack &&
     compare_action_field_a == EBTCO_ACT_TOGGLE && !wr_cnt && !wr_flags)
    |=> compare_output_a != $past(compare_output_a) &&
        compare_flag_a == $past(compare_flag_a) && $stable(counter_value))
    else $error("forced compare misbehaved");

  pin_source_a: assert property ( // R5 R6 R7
    (compare_action_field_a != EBTCO_ACT_NONE) ##1 (compare_action_field_a != EBTCO_ACT_NONE)
    |-> pin_a_out == compare_output_a && pin_a_oe == compare_pin_direction_bit_a)
    else $error("pin a not from compare output");

  reset_out_a: assert property (@(posedge clk) disable iff (1'b0) // R4
    srst |=> !compare_output_a && !compare_output_b)
    else $error("compare outputs not cleared by reset");

  flag_b_set_a: assert property ( // R23
    (timer_tick && !match_block && counter_value == compare_value_b) |=> compare_flag_b)
    else $error("compare flag b not set on match");

  mode_keeps_out_a: assert property ( // R3
    (wr_ctrl && !timer_tick) |=> $stable(compare_output_a) && $stable(compare_output_b))
    else $error("control write moved a compare output");

  pwm_no_action_a: assert property ( // R9
    !non_pwm |=> $stable(compare_output_a) && $stable(compare_output_b))
    else $error("compare output moved in a pwm mode");

  cover_match_toggle: cover property (
    waveform_mode_select == EBTCO_MODE_CLRMATCH && match_a &&
    compare_action_field_a == EBTCO_ACT_TOGGLE);
  cover_overflow: cover property ($rose(overflow_flag));
  cover_force: cover property (force_a && compare_action_field_a != EBTCO_ACT_NONE);
  cover_blocked: cover property (
    timer_tick && match_block && counter_value == compare_value_a);

endmodule : ebtco_timer

// ==== core/ebtco_defs.svh ====
`ifndef EBTCO_DEFS_SVH
`define EBTCO_DEFS_SVH

// register byte offsets
`define EBTCO_OFF_CTRL 8'h00
`define EBTCO_OFF_COUNT 8'h04
`define EBTCO_OFF_CMPA 8'h08
`define EBTCO_OFF_CMPB 8'h0c
`define EBTCO_OFF_FORCE 8'h10
`define EBTCO_OFF_FLAGS 8'h14
`define EBTCO_OFF_PORT 8'h18
`define EBTCO_OFF_OUTS 8'h1c

// ctrl fields
`define EBTCO_CTRL_WGM 2:0
`define EBTCO_CTRL_ACTA 5:4
`define EBTCO_CTRL_ACTB 7:6

// force, flag, port and output bit positions
`define EBTCO_BIT_A 0
`define EBTCO_BIT_B 1
`define EBTCO_FLG_OVF 0
`define EBTCO_FLG_CMPA 1
`define EBTCO_FLG_CMPB 2
`define EBTCO_PORT_VALA 0
`define EBTCO_PORT_VALB 1
`define EBTCO_PORT_DIRA 2
`define EBTCO_PORT_DIRB 3

// counter values and reset values
`define EBTCO_CNT_MAX 8'hff
`define EBTCO_CNT_ZERO 8'h00
`define EBTCO_CNT_ONE 8'h01
`define EBTCO_RST_BYTE 8'h00
`define EBTCO_RST_WORD 32'h0000_0000

`endif

// ==== core/ebtco_pkg.sv ====
package ebtco_pkg;

  typedef enum logic [2:0] {
    EBTCO_MODE_NORMAL = 3'b000,
    EBTCO_MODE_PCPWM = 3'b001,
    EBTCO_MODE_CLRMATCH = 3'b010,
    EBTCO_MODE_FPWM = 3'b011,
    EBTCO_MODE_RSV4 = 3'b100,
    EBTCO_MODE_PCPWM_T = 3'b101,
    EBTCO_MODE_RSV6 = 3'b110,
    EBTCO_MODE_FPWM_T = 3'b111
  } ebtco_mode_e;

  typedef enum logic [1:0] {
    EBTCO_ACT_NONE = 2'b00,
    EBTCO_ACT_TOGGLE = 2'b01,
    EBTCO_ACT_CLEAR = 2'b10,
    EBTCO_ACT_SET = 2'b11
  } ebtco_act_e;

  typedef logic [7:0] ebtco_byte_t;

endpackage : ebtco_pkg

// ==== verif/ebtco_timer_tb.sv ====
`timescale 1ns/10ps
`include "ebtco_defs.svh"
`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("BAD t=%0t %s got %0h exp %0h", $time, msg, got, exp); end end
module ebtco_timer_tb;
  import ebtco_pkg::*;
  typedef struct packed {logic [1:0] act; logic out;} ebtco_frow_s;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic timer_tick = 1'h0;
  logic ovf_int_ack = 1'h0;
  logic cmpa_int_ack = 1'h0;
  logic cmpb_int_ack = 1'h0;
  logic [31:0] prdata;
  logic pready, pslverr, overflow_flag, compare_flag_a, compare_flag_b;
  logic pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
  ebtco_byte_t counter_value;
  int checks = 0;
  int n_mismatch = 0;
  int cyc = 0;
  logic [31:0] q;
  logic err;
  logic eo;
  ebtco_byte_t ec;
  // force table from out=0: set, toggle, clear, toggle, none, clear
  ebtco_frow_s rows [6] = '{'{2'h3, 1'h1}, '{2'h1, 1'h0}, '{2'h2, 1'h0},
                            '{2'h1, 1'h1}, '{2'h0, 1'h1}, '{2'h2, 1'h0}};

  ebtco_timer i_ebtco_timer (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_tick(timer_tick), .ovf_int_ack(ovf_int_ack),
    .cmpa_int_ack(cmpa_int_ack), .cmpb_int_ack(cmpb_int_ack),
    .overflow_flag(overflow_flag), .compare_flag_a(compare_flag_a),
    .compare_flag_b(compare_flag_b), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
    .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe), .counter_value(counter_value));

  always #20 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("counts: checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // the run is a few hundred cycles; a hang is cut well beyond that
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // one apb transfer; wait on pready, never on a fixed count
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) begin
      @(posedge clk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    #1;
  endtask : apb

  task automatic ticks(input int n);
    @(posedge clk);
    timer_tick <= 1'h1;
    repeat (n) @(posedge clk);
    timer_tick <= 1'h0;
    #1;
  endtask : ticks

  task automatic pulse_ack;
    @(posedge clk);
    ovf_int_ack <= 1'h1;
    cmpa_int_ack <= 1'h1;
    @(posedge clk);
    ovf_int_ack <= 1'h0;
    cmpa_int_ack <= 1'h0;
    #1;
  endtask : pulse_ack

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'h0;
    #1;
    `CHK(counter_value, 8'h00, "reset count")
    `CHK({overflow_flag, compare_flag_a, pin_a_oe, pin_a_out}, 4'h0, "reset outs")
    apb(1'h1, `EBTCO_OFF_OUTS - 8'h1c, 32'h0);
    apb(1'h0, `EBTCO_OFF_OUTS, 32'h0);
    `CHK(q[1:0], 2'h0, "reset compare bits")
    $display("test reset done");

    // ordinary cases: force strobe with each action in normal mode
    foreach (rows[i]) begin
      apb(1'h1, `EBTCO_OFF_CTRL, {26'h0, rows[i].act, 4'h0});
      apb(1'h1, `EBTCO_OFF_FORCE, 32'h1);
      apb(1'h0, `EBTCO_OFF_OUTS, 32'h0);
      `CHK(q[0], rows[i].out, "force out")
      `CHK(pin_a_out, (rows[i].act != 2'h0) ? rows[i].out : 1'h0, "pin source")
      `CHK({compare_flag_a, counter_value}, 9'h000, "force no flag")
    end
    // level set by force first, only then the pin is made an output
    apb(1'h1, `EBTCO_OFF_PORT, 32'h04);
    `CHK(pin_a_oe, 1'h1, "dir a")
    $display("test force table done");

    // normal wrap and overflow flag
    apb(1'h1, `EBTCO_OFF_COUNT, 32'hfd);
    ticks(2);
    `CHK({overflow_flag, counter_value}, 9'h0ff, "up to ff")
    ticks(1);
    `CHK({overflow_flag, counter_value}, 9'h100, "wrap ovf")
    pulse_ack();
    `CHK(overflow_flag, 1'h0, "ack clears")
    repeat (5) @(posedge clk);
    #1;
    `CHK(counter_value, 8'h00, "no tick no count")
    ticks(1);
    `CHK({compare_flag_a, counter_value}, 9'h101, "match flag")
    pulse_ack();
    $display("test normal done");

    // counter write blocks the next match, even while stopped
    apb(1'h1, `EBTCO_OFF_CTRL, 32'h10);
    apb(1'h1, `EBTCO_OFF_CMPA, 32'h10);
    apb(1'h1, `EBTCO_OFF_COUNT, 32'h10);
    repeat (3) @(posedge clk);
    ticks(1);
    `CHK({compare_flag_a, pin_a_out, counter_value}, 10'h011, "blocked match")
    @(posedge clk);
    timer_tick <= 1'h1;
    apb(1'h1, `EBTCO_OFF_COUNT, 32'h40);
    timer_tick <= 1'h0;
    `CHK(counter_value, 8'h40, "write beats tick")
    $display("test blocking done");

    // clear on match with toggle, top 2
    apb(1'h1, `EBTCO_OFF_CTRL, 32'h12);
    apb(1'h1, `EBTCO_OFF_CMPA, 32'h02);
    apb(1'h1, `EBTCO_OFF_COUNT, 32'h00);
    ec = 8'h00;
    eo = 1'h0;
    for (int i = 0; i < 6; i++) begin
      ticks(1);
      if (ec == 8'h02) begin
        ec = 8'h00;
        eo = ~eo;
      end else begin
        ec = ec + 8'h01;
      end
      `CHK(counter_value, ec, "clear count")
      `CHK(pin_a_out, eo, "match toggle")
      if (i == 2) `CHK(compare_flag_a, 1'h1, "top flag")
    end
    $display("test clear on match done");

    // top below count: run through ff and wrap first
    apb(1'h1, `EBTCO_OFF_FLAGS, 32'h07);
    apb(1'h1, `EBTCO_OFF_COUNT, 32'h05);
    ticks(250);
    `CHK({overflow_flag, compare_flag_a, counter_value}, 10'h0ff, "late top")
    ticks(1);
    `CHK({overflow_flag, compare_flag_a, counter_value}, 10'h200, "clear mode ovf")
    ticks(3);
    eo = ~eo;
    `CHK({compare_flag_a, pin_a_out, counter_value}, {2'h1, eo, 8'h00}, "wrap match")
    $display("test late top done");

    // mode change keeps output; action none leaves it on a match
    apb(1'h1, `EBTCO_OFF_CTRL, 32'h13);
    `CHK(pin_a_out, eo, "mode change")
    apb(1'h1, `EBTCO_OFF_CTRL, 32'h00);
    `CHK(pin_a_out, 1'h0, "port value")
    apb(1'h1, `EBTCO_OFF_FLAGS, 32'h07);
    ticks(3);
    apb(1'h0, `EBTCO_OFF_OUTS, 32'h0);
    `CHK({compare_flag_a, q[0]}, {1'h1, eo}, "action none")
    `CHK(counter_value, 8'h03, "normal no clear")
    `CHK(compare_flag_b, 1'h1, "flag b set")
    apb(1'h1, `EBTCO_OFF_PORT, 32'h0a);
    `CHK({pin_a_oe, pin_b_oe, pin_b_out}, 3'h3, "port b pin")
    apb(1'h0, 8'h20, 32'h0);
    `CHK({err, q}, 33'h100000000, "unmapped")
    $display("test mode and action done");

    // reset in mid-run while compare output a is high
    @(posedge clk);
    srst <= 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    #1;
    `CHK({counter_value, pin_b_oe, overflow_flag}, 10'h000, "mid reset")
    apb(1'h0, `EBTCO_OFF_OUTS, 32'h0);
    `CHK(q[1:0], 2'h0, "mid reset compare bits")
    $display("test reset again done");
    give_verdict();
  end
endmodule : ebtco_timer_tb
